// >>> hw/psi_consts.svh
/*
  Register map, field positions, reset values and widths of the PHY
  status interrupt unit. Assumes inclusion by bare name from hw/.
*/
`ifndef PSI_CONSTS_SVH
`define PSI_CONSTS_SVH

// --------------------------------------------------------------------
// Extended register offsets
// --------------------------------------------------------------------
`define PSI_ADDR_STATUS_LO 16'h810D
`define PSI_ADDR_STATUS_HI 16'h810E
`define PSI_ADDR_CAUSE_LO 16'h810F
`define PSI_ADDR_CAUSE_HI 16'h8110
`define PSI_ADDR_LIVE_LO 16'h8111
`define PSI_ADDR_LIVE_HI 16'h8112
`define PSI_ADDR_MASK_LO 16'h8113
`define PSI_ADDR_MASK_HI 16'h8114
`define PSI_ADDR_ACK_LO 16'h8115
`define PSI_ADDR_ACK_HI 16'h8116
`define PSI_ADDR_OUT_CTRL 16'h8117

// --------------------------------------------------------------------
// Low group status bits
// --------------------------------------------------------------------
`define PSI_ST_LINK 0
`define PSI_ST_SPEED 1
`define PSI_ST_DUPLEX 2
`define PSI_ST_CONFIG 3
`define PSI_ST_LO_W 4

// --------------------------------------------------------------------
// Low group cause and live field positions
// --------------------------------------------------------------------
`define PSI_FL_LINK 0
`define PSI_FL_SPEED_LSB 1
`define PSI_FL_SPEED_MSB 2
`define PSI_FL_DUPLEX 3
`define PSI_FL_CONFIG 4
`define PSI_FL_LO_W 5

// --------------------------------------------------------------------
// Output control bits and reset values
// --------------------------------------------------------------------
`define PSI_CTRL_ENABLE 0
`define PSI_CTRL_POL_HIGH 1
`define PSI_CTRL_LATCHED 2
`define PSI_CTRL_W 3
`define PSI_CTRL_RESET 3'h0
`define PSI_MASK_RESET 16'h0000
`define PSI_IRQ_RESET_LEVEL 1'b1
`define PSI_REG_W 16
`define PSI_HI_W 16

`endif

// >>> hw/psi_pkg.sv
/*
  Types of the PHY status interrupt unit: the held link attributes
  and the whole state of the unit as one packed struct.
  Assumes psi_consts.svh is on the include path.
*/
`include "psi_consts.svh"

package psi_pkg;

  // ------------------------------------------------------------------
  // Link attributes kept from the last link-up period
  // ------------------------------------------------------------------
  typedef struct packed {
    logic config_bit;
    logic duplex;
    logic [1:0] speed;
  } psi_held_t;

  // ------------------------------------------------------------------
  // Complete state of the unit
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [`PSI_REG_W-1:0] mask_lo;
    logic [`PSI_REG_W-1:0] mask_hi;
    logic [`PSI_CTRL_W-1:0] ctrl;
    logic [`PSI_ST_LO_W-1:0] status_lo;
    logic [`PSI_HI_W-1:0] status_hi;
    logic [`PSI_FL_LO_W-1:0] cause_lo;
    logic [`PSI_HI_W-1:0] cause_hi;
    logic [`PSI_FL_LO_W-1:0] ref_lo;
    logic [`PSI_HI_W-1:0] ref_hi;
    logic [`PSI_ST_LO_W-1:0] ack_lo;
    logic [`PSI_HI_W-1:0] ack_hi;
    psi_held_t held;
    logic latch;
    logic irq;
    logic [`PSI_REG_W-1:0] rdata;
  } psi_state_t;

endpackage : psi_pkg

// >>> hw/psi_irq_unit.sv
/*
  Interrupt unit of an Ethernet PHY: live, cause, status, mask, ack
  and output control registers, plus one push-pull interrupt pin.
  Assumes monitored status inputs come from logic on i_clk and a
  management front end that drives the plain register port.
*/
`timescale 1ns/10ps
`default_nettype none
`include "psi_consts.svh"

// Behaviour
// - Interrupt pin reports changes of monitored status without host polling.
// - Reset disables the interrupt and restores every register default.
// - Output control register selects active-high or active-low pin polarity.
// - Non-latched mode: pin asserted while any enabled status bit is set.
// - Status bit at one with its mask bit set asserts the pin.
// - Only status register bits feed the interrupt pin.
// - Writing one to an ack bit clears the matching status bit.
// - Ack bits return to zero by themselves one cycle after the write.
// - Interrupt pin is push-pull, never open drain.
// - Speed, duplex, config live fields hold values from last link-up period.
// - Setting a status bit stores its cause in the cause register.
// - A cause field stays frozen until its interrupt is serviced.
// - Writing one to an ack bit also clears the matching cause field.
// - New event when stored cause copy and live value differ.
// - All interrupt registers sit in the extended address space.
// - Register port keeps answering while isolated or powered down.
module psi_irq_unit #(
  parameter int AUX_WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_link_up,
  input wire logic [1:0] i_speed,
  input wire logic i_duplex,
  input wire logic i_config,
  input wire logic [AUX_WIDTH-1:0] i_aux_status,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_irq
);

  // ------------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------------
  // High group has one register of 16 sources.
  if (AUX_WIDTH < 1 || AUX_WIDTH > `PSI_HI_W) begin : g_bad_width
    $error("AUX_WIDTH must be 1 to 16");
  end

  // Low group images must fit one register.
  if (`PSI_FL_LO_W > `PSI_REG_W || `PSI_ST_LO_W > `PSI_REG_W) begin : g_bad_lo_width
    $error("low group wider than a register");
  end

  // Control image must fit one register.
  if (`PSI_CTRL_W > `PSI_REG_W) begin : g_bad_ctrl_width
    $error("control wider than a register");
  end

  // Speed field is two bits wide, as the speed port.
  if (`PSI_FL_SPEED_MSB - `PSI_FL_SPEED_LSB != 1) begin : g_bad_speed_field
    $error("speed field must be two bits");
  end

  // ------------------------------------------------------------------
  // Reset value of the whole state
  // ------------------------------------------------------------------
  localparam psi_pkg::psi_state_t RESET_STATE = '{
    mask_lo: `PSI_MASK_RESET,
    mask_hi: `PSI_MASK_RESET,
    ctrl: `PSI_CTRL_RESET,
    status_lo: '0,
    status_hi: '0,
    cause_lo: '0,
    cause_hi: '0,
    ref_lo: '0,
    ref_hi: '0,
    ack_lo: '0,
    ack_hi: '0,
    held: '0,
    latch: 1'b0,
    irq: `PSI_IRQ_RESET_LEVEL,
    rdata: '0
  };

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Zero-extend a narrow field into a 16-bit register image.
  function automatic logic [15:0] psi_pad_lo(input logic [`PSI_FL_LO_W-1:0] v);
    psi_pad_lo = {{(16 - `PSI_FL_LO_W){1'b0}}, v};
  endfunction : psi_pad_lo

  function automatic logic [15:0] psi_pad_st(input logic [`PSI_ST_LO_W-1:0] v);
    psi_pad_st = {{(16 - `PSI_ST_LO_W){1'b0}}, v};
  endfunction : psi_pad_st

  // Register read mux; unmapped addresses read as zero.
  // lo offset low group, hi offset high group
  function automatic logic [15:0] psi_read(
    input logic [15:0] addr,
    input psi_pkg::psi_state_t s,
    input logic [`PSI_FL_LO_W-1:0] live_lo,
    input logic [`PSI_HI_W-1:0] live_hi
  );
    case (addr)
      `PSI_ADDR_STATUS_LO: begin
        psi_read = psi_pad_st(s.status_lo);
      end
      `PSI_ADDR_STATUS_HI: begin
        psi_read = s.status_hi;
      end
      `PSI_ADDR_CAUSE_LO: begin
        psi_read = psi_pad_lo(s.cause_lo);
      end
      `PSI_ADDR_CAUSE_HI: begin
        psi_read = s.cause_hi;
      end
      `PSI_ADDR_LIVE_LO: begin
        psi_read = psi_pad_lo(live_lo);
      end
      `PSI_ADDR_LIVE_HI: begin
        psi_read = live_hi;
      end
      `PSI_ADDR_MASK_LO: begin
        psi_read = s.mask_lo;
      end
      `PSI_ADDR_MASK_HI: begin
        psi_read = s.mask_hi;
      end
      `PSI_ADDR_ACK_LO: begin
        psi_read = psi_pad_st(s.ack_lo);
      end
      `PSI_ADDR_ACK_HI: begin
        psi_read = s.ack_hi;
      end
      `PSI_ADDR_OUT_CTRL: begin
        psi_read = {{(16 - `PSI_CTRL_W){1'b0}}, s.ctrl};
      end
      default: begin
        psi_read = 16'h0000;
      end
    endcase
  endfunction : psi_read

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  psi_pkg::psi_state_t q;
  psi_pkg::psi_state_t d;
  logic [`PSI_HI_W-1:0] aux_pad;
  logic [`PSI_FL_LO_W-1:0] live_lo;
  logic [`PSI_HI_W-1:0] live_hi;
  logic [`PSI_ST_LO_W-1:0] diff_lo;
  logic [`PSI_ST_LO_W-1:0] event_lo;
  logic [`PSI_HI_W-1:0] event_hi;
  logic pending;

  always_comb begin
    aux_pad = '0;
    aux_pad[AUX_WIDTH-1:0] = i_aux_status;
  end

  // ------------------------------------------------------------------
  // Live view of the monitored signals
  // ------------------------------------------------------------------
  always_comb begin
    live_lo = '0;
    live_lo[`PSI_FL_LINK] = i_link_up;
    // attributes from last link-up
    // Held copy keeps link-down reads meaningful.
    if (i_link_up) begin
      live_lo[`PSI_FL_SPEED_MSB:`PSI_FL_SPEED_LSB] = i_speed;
      live_lo[`PSI_FL_DUPLEX] = i_duplex;
      live_lo[`PSI_FL_CONFIG] = i_config;
    end else begin
      live_lo[`PSI_FL_SPEED_MSB:`PSI_FL_SPEED_LSB] = q.held.speed;
      live_lo[`PSI_FL_DUPLEX] = q.held.duplex;
      live_lo[`PSI_FL_CONFIG] = q.held.config_bit;
    end
    live_hi = aux_pad;
  end

  // ------------------------------------------------------------------
  // Change detection against the stored cause copy
  // ------------------------------------------------------------------
  always_comb begin
    diff_lo[`PSI_ST_LINK] = live_lo[`PSI_FL_LINK] != q.ref_lo[`PSI_FL_LINK];
    diff_lo[`PSI_ST_SPEED] = live_lo[`PSI_FL_SPEED_MSB:`PSI_FL_SPEED_LSB]
                             != q.ref_lo[`PSI_FL_SPEED_MSB:`PSI_FL_SPEED_LSB];
    diff_lo[`PSI_ST_DUPLEX] = live_lo[`PSI_FL_DUPLEX] != q.ref_lo[`PSI_FL_DUPLEX];
    diff_lo[`PSI_ST_CONFIG] = live_lo[`PSI_FL_CONFIG] != q.ref_lo[`PSI_FL_CONFIG];
    // no new event while one is pending
    // A bit being acked this cycle counts as free, so the set wins.
    // Stored copy survives ack, so a reported state never rings twice.
    event_lo = diff_lo & (~q.status_lo | q.ack_lo);
    event_hi = (live_hi ^ q.ref_hi) & (~q.status_hi | q.ack_hi);
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    d.rdata = 16'h0000;
    if (i_link_up) begin
      d.held.speed = i_speed;
      d.held.duplex = i_duplex;
      d.held.config_bit = i_config;
    end

    // ack bits drop after one cycle
    d.status_lo = (q.status_lo & ~q.ack_lo) | event_lo;
    d.status_hi = (q.status_hi & ~q.ack_hi) | event_hi;
    d.ack_lo = '0;
    d.ack_hi = '0;

    if (q.ack_lo[`PSI_ST_LINK]) begin
      d.cause_lo[`PSI_FL_LINK] = 1'b0;
    end
    if (q.ack_lo[`PSI_ST_SPEED]) begin
      d.cause_lo[`PSI_FL_SPEED_MSB:`PSI_FL_SPEED_LSB] = 2'h0;
    end
    if (q.ack_lo[`PSI_ST_DUPLEX]) begin
      d.cause_lo[`PSI_FL_DUPLEX] = 1'b0;
    end
    if (q.ack_lo[`PSI_ST_CONFIG]) begin
      d.cause_lo[`PSI_FL_CONFIG] = 1'b0;
    end
    d.cause_hi = q.cause_hi & ~q.ack_hi;

    // store the cause on a new event
    if (event_lo[`PSI_ST_LINK]) begin
      d.cause_lo[`PSI_FL_LINK] = live_lo[`PSI_FL_LINK];
      d.ref_lo[`PSI_FL_LINK] = live_lo[`PSI_FL_LINK];
    end
    if (event_lo[`PSI_ST_SPEED]) begin
      d.cause_lo[`PSI_FL_SPEED_MSB:`PSI_FL_SPEED_LSB] =
        live_lo[`PSI_FL_SPEED_MSB:`PSI_FL_SPEED_LSB];
      d.ref_lo[`PSI_FL_SPEED_MSB:`PSI_FL_SPEED_LSB] =
        live_lo[`PSI_FL_SPEED_MSB:`PSI_FL_SPEED_LSB];
    end
    if (event_lo[`PSI_ST_DUPLEX]) begin
      d.cause_lo[`PSI_FL_DUPLEX] = live_lo[`PSI_FL_DUPLEX];
      d.ref_lo[`PSI_FL_DUPLEX] = live_lo[`PSI_FL_DUPLEX];
    end
    if (event_lo[`PSI_ST_CONFIG]) begin
      d.cause_lo[`PSI_FL_CONFIG] = live_lo[`PSI_FL_CONFIG];
      d.ref_lo[`PSI_FL_CONFIG] = live_lo[`PSI_FL_CONFIG];
    end
    d.cause_hi = (d.cause_hi & ~event_hi) | (live_hi & event_hi);
    d.ref_hi = (q.ref_hi & ~event_hi) | (live_hi & event_hi);

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // decode of extended offsets only
    // no power or isolate gating on the port
    if (i_wr) begin
      case (i_addr)
        `PSI_ADDR_MASK_LO: begin
          d.mask_lo = i_wdata;
        end
        `PSI_ADDR_MASK_HI: begin
          d.mask_hi = i_wdata;
        end
        `PSI_ADDR_ACK_LO: begin
          d.ack_lo = i_wdata[`PSI_ST_LO_W-1:0];
        end
        `PSI_ADDR_ACK_HI: begin
          d.ack_hi = i_wdata;
        end
        `PSI_ADDR_OUT_CTRL: begin
          d.ctrl = i_wdata[`PSI_CTRL_W-1:0];
        end
        // Read-only and unmapped offsets ignore writes
        default: begin
          d.ctrl = q.ctrl;
        end
      endcase
    end

    if (i_rd) begin
      d.rdata = psi_read(i_addr, q, live_lo, live_hi);
    end

    // ----------------------------------------------------------------
    // Interrupt pin
    // ----------------------------------------------------------------
    // only status bits are sources
    pending = (|(q.status_lo & q.mask_lo[`PSI_ST_LO_W-1:0]))
              | (|(q.status_hi & q.mask_hi));
    // level follows pending bits
    // Latched mode holds the pin until an ack write lands while no enabled status bit is set, so a
    // mask change alone cannot hide an event the host has not seen.
    if (!q.ctrl[`PSI_CTRL_ENABLE]) begin
      d.latch = 1'b0;
    end else if (q.ctrl[`PSI_CTRL_LATCHED]) begin
      d.latch = pending | (q.latch & ~((|q.ack_lo) | (|q.ack_hi)));
    end else begin
      d.latch = pending;
    end
    d.irq = d.latch ? q.ctrl[`PSI_CTRL_POL_HIGH] : ~q.ctrl[`PSI_CTRL_POL_HIGH];
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    // everything to defaults, pin disabled
    // Synchronous reset: one edge restores every field.
    if (i_sys_rst) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // push-pull: pin always driven
  // Read data is zero outside its one cycle, so a late sample shows.
  assign o_irq = q.irq;
  assign o_rdata = q.rdata;

endmodule : psi_irq_unit
`default_nettype wire

// >>> verification/psi_irq_checker_assertions.sv
/* Port checker of the PHY status interrupt unit.
   Assumes a bind onto psi_irq_unit, one clock i_clk. */
`timescale 1ns/10ps
`default_nettype none
module psi_irq_checker #(
  parameter int AUX_WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_link_up,
  input wire logic [1:0] i_speed,
  input wire logic i_duplex,
  input wire logic i_config,
  input wire logic [AUX_WIDTH-1:0] i_aux_status,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_irq
);
  logic [2:0] ctrl_q;
  logic mask0_q;
  // ------------
  // Shadow of control and mask bit 0
  // ------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= 3'h0;
      mask0_q <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == 16'h8117) ctrl_q <= i_wdata[2:0];
      if (i_addr == 16'h8113) mask0_q <= i_wdata[0];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data not zero");
  a_reset_pin: assert property ($past(i_sys_rst) |-> o_irq && o_rdata == 16'h0000)
    else $error("bad state after reset");
  a_unmapped_read: assert property (i_rd && (i_addr < 16'h810D || i_addr > 16'h8117) |=> !o_rdata)
    else $error("unmapped read not zero");
  a_mask_readback: assert property (i_wr && i_addr == 16'h8113 ##1 i_rd && i_addr == 16'h8113
    |=> o_rdata == $past(i_wdata, 2))
    else $error("mask readback wrong");
  a_ctrl_readback: assert property (i_wr && i_addr == 16'h8117 ##1 i_rd && i_addr == 16'h8117
    |=> o_rdata == ($past(i_wdata, 2) & 16'h0007))
    else $error("control readback wrong");
  a_live_link: assert property (i_rd && i_addr == 16'h8111 && $stable(i_link_up)
    |=> o_rdata[0] == $past(i_link_up))
    else $error("live link bit wrong");
  // Pin only idles once control has settled
  a_idle_level: assert property (!ctrl_q[0] && $stable(ctrl_q) |-> o_irq == !ctrl_q[1])
    else $error("disabled pin not inactive");
  a_ack_readback: assert property (i_wr && i_addr == 16'h8115 ##1 i_rd && i_addr == 16'h8115
    |=> o_rdata == ($past(i_wdata, 2) & 16'h000F))
    else $error("ack readback wrong");
  a_ack_selfclear: assert property (i_wr && i_addr == 16'h8115 ##1 !i_wr ##1 i_rd && i_addr == 16'h8115
    |=> o_rdata == 16'h0000)
    else $error("ack bits not cleared");
  a_link_irq: assert property (!i_wr[*3] ##1 ($rose(i_link_up) && ctrl_q[1:0] == 2'h3 && mask0_q && !i_wr)
    ##1 !i_wr[*2] |-> o_irq)
    else $error("link event missed pin");
endmodule : psi_irq_checker
bind psi_irq_unit psi_irq_checker #(.AUX_WIDTH(AUX_WIDTH)) chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_link_up(i_link_up), .i_speed(i_speed), .i_duplex(i_duplex), .i_config(i_config),
  .i_aux_status(i_aux_status), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_irq(o_irq));
`default_nettype wire

// >>> verification/psi_host_model.sv
/* Host side of the register port: one-cycle strobes.
   Assumes the unit answers reads one cycle later. */
`timescale 1ns/10ps
`default_nettype none
module psi_host_model (
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  output logic [15:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  logic rd_q = 1'b0;
  logic [15:0] got = 16'h0000;
  initial begin
    o_addr = 16'h0000;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  always @(posedge i_clk) begin
    rd_q <= o_rd;
    if (rd_q) got <= i_rdata;
  end
  // ------------
  // Bus cycles
  // ------------
  // Idle lines toggle so stale values never pass
  task cyc(input logic w, input logic r, input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_wr <= w;
    o_rd <= r;
    o_addr <= (w | r) ? a : ~o_addr;
    o_wdata <= w ? d : ~o_wdata;
  endtask : cyc
  task wr(input logic [15:0] a, input logic [15:0] d);
    cyc(1'b1, 1'b0, a, d);
    cyc(1'b0, 1'b0, a, d);
  endtask : wr
  task rd(input logic [15:0] a, output logic [15:0] d);
    cyc(1'b0, 1'b1, a, 16'h0000);
    cyc(1'b0, 1'b0, a, 16'h0000);
    @(posedge i_clk);
    @(negedge i_clk);
    d = got;
  endtask : rd
endmodule : psi_host_model
`default_nettype wire

// >>> verification/psi_irq_unit_tb.sv
/* Self-checking bench of the PHY status interrupt unit.
   Assumes the checker bind and the host model beside it. */
`timescale 1ns/10ps
`default_nettype none
module psi_irq_unit_tb;
  logic i_clk = 1'b0;
  logic rst = 1'b1;
  logic link = 1'b0;
  logic dup = 1'b0;
  logic cfg = 1'b0;
  logic irq, wr, rd;
  logic [1:0] spd = 2'h0;
  logic [1:0] sp;
  logic [15:0] aux = 16'h0000;
  logic [15:0] addr, wdata, rdata, rv, a0, a1;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 48;
  psi_irq_unit #(.AUX_WIDTH(16)) dut_u (.i_clk(i_clk), .i_sys_rst(rst), .i_link_up(link), .i_speed(spd),
    .i_duplex(dup), .i_config(cfg), .i_aux_status(aux), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_irq(irq));
  psi_host_model host_u (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
    .o_rd(rd));
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  // ------------
  // Helpers
  // ------------
  function automatic logic [15:0] fld(logic l, logic [1:0] s, logic d, logic c);
    return {11'h000, c, d, s, l};
  endfunction : fld
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task rchk(input logic [15:0] a, input logic [15:0] exp);
    host_u.rd(a, rv);
    chk(rv, exp);
  endtask : rchk
  task wt(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask : wt
  task st(input logic l, input logic [1:0] s, input logic d, input logic c);
    @(posedge i_clk);
    link <= l;
    spd <= s;
    dup <= d;
    cfg <= c;
  endtask : st
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // Hang guard, far above the expected run
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test;
    end
  end
  // ------------
  // Main sequence
  // ------------
  initial begin
    repeat (4) @(posedge i_clk);
    rst <= 1'b0;
    wt(1);
    chk({15'h0000, irq}, 16'h0001);
    for (int i = 0; i < 13; i++) rchk(16'h810C + 16'(i), 16'h0000);
    $display("done reset");
    a0 = 16'($random(seed));
    host_u.wr(16'h8114, a0);
    rchk(16'h8114, a0);
    host_u.wr(16'h810D, 16'hFFFF);
    rchk(16'h810D, 16'h0000);
    host_u.wr(16'h8117, 16'hFFFA);
    rchk(16'h8117, 16'h0002);
    host_u.cyc(1'b1, 1'b0, 16'h8113, 16'h0001);
    host_u.cyc(1'b0, 1'b1, 16'h8113, 16'h0000);
    host_u.cyc(1'b1, 1'b0, 16'h8117, 16'h0003);
    host_u.cyc(1'b0, 1'b1, 16'h8117, 16'h0000);
    host_u.cyc(1'b1, 1'b0, 16'h8115, 16'h0001);
    host_u.cyc(1'b0, 1'b1, 16'h8115, 16'h0000);
    host_u.rd(16'h8115, rv);
    chk(rv, 16'h0000);
    wt(5);
    chk({15'h0000, irq}, 16'h0000);
    $display("done registers");
    sp = 2'($random(seed));
    st(1'b1, sp, 1'b1, 1'b1);
    wt(3);
    chk({15'h0000, irq}, 16'h0001);
    rchk(16'h810D, {12'h000, 2'h3, sp != 2'h0, 1'b1});
    rchk(16'h810F, fld(1'b1, sp, 1'b1, 1'b1));
    rchk(16'h8111, fld(1'b1, sp, 1'b1, 1'b1));
    st(1'b0, sp, 1'b1, 1'b1);
    st(1'b1, sp, 1'b1, 1'b1);
    st(1'b0, ~sp, 1'b0, 1'b0);
    wt(2);
    rchk(16'h8111, fld(1'b0, sp, 1'b1, 1'b1));
    rchk(16'h810F, fld(1'b1, sp, 1'b1, 1'b1));
    host_u.wr(16'h8115, 16'h0001);
    wt(4);
    rchk(16'h810F, fld(1'b0, sp, 1'b1, 1'b1));
    rchk(16'h810D, {12'h000, 2'h3, sp != 2'h0, 1'b1});
    host_u.wr(16'h8117, 16'h0001);
    wt(3);
    chk({15'h0000, irq}, 16'h0000);
    host_u.wr(16'h8117, 16'h0000);
    wt(3);
    chk({15'h0000, irq}, 16'h0001);
    host_u.wr(16'h8117, 16'h0003);
    wt(3);
    chk({15'h0000, irq}, 16'h0001);
    host_u.wr(16'h8115, 16'h000F);
    wt(4);
    rchk(16'h810D, 16'h0000);
    rchk(16'h810F, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    $display("done link");
    host_u.wr(16'h8114, 16'hFFFF);
    a0 = 16'h0000;
    repeat (4) begin
      a1 = 16'($random(seed));
      @(posedge i_clk);
      aux <= a1;
      wt(3);
      chk({15'h0000, irq}, {15'h0000, a1 != a0});
      rchk(16'h810E, a1 ^ a0);
      rchk(16'h8110, a1 & (a1 ^ a0));
      rchk(16'h8112, a1);
      host_u.wr(16'h8116, 16'hFFFF);
      wt(3);
      rchk(16'h810E, 16'h0000);
      a0 = a1;
    end
    $display("done aux");
    host_u.wr(16'h8117, 16'h0007);
    a1 = 16'($random(seed)) | 16'h0001;
    @(posedge i_clk);
    aux <= a0 ^ a1;
    wt(3);
    chk({15'h0000, irq}, 16'h0001);
    host_u.wr(16'h8114, 16'h0000);
    wt(3);
    chk({15'h0000, irq}, 16'h0001);
    host_u.wr(16'h8116, 16'hFFFF);
    wt(3);
    chk({15'h0000, irq}, 16'h0000);
    rchk(16'h810E, 16'h0000);
    $display("done latched");
    stop_test;
  end
endmodule : psi_irq_unit_tb
`default_nettype wire
